/* src/alc_pkg.sv */
package alc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] ALC_ADDR_CFG_A = 8'h1b;
    localparam logic [7:0] ALC_ADDR_CFG_B = 8'h1c;
    localparam logic [7:0] ALC_CFG_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // field positions inside both configuration registers
    localparam int ALC_SENSOR_A_FILTER_PERIOD_MSB = 7;
    localparam int ALC_SENSOR_A_FILTER_PERIOD_LSB = 5;
    localparam int ALC_FORCE_BIT = 4;
    localparam int ALC_DARK_RES_BIT = 3;
    localparam int ALC_OFFICE_RES_BIT = 2;
    localparam int ALC_DARK_EN_BIT = 1;
    localparam int ALC_OFFICE_EN_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned ALC_CLK_KHZ = 40000;
    localparam int unsigned ALC_SENSOR_A_FILTER_PERIOD_BASE_MS = 80;
    localparam int unsigned ALC_SENSOR_A_FILTER_PERIOD_MAX_MS = 10240;
    localparam int unsigned ALC_SENSOR_A_FILTER_PERIOD_BASE_CYC = ALC_SENSOR_A_FILTER_PERIOD_BASE_MS * ALC_CLK_KHZ;
    localparam int ALC_CNT_W = 32;

    ////////////////////////////////////////////////////////////////////////
    // channel and level indices
    localparam int ALC_NUM_CH = 2;
    localparam int ALC_NUM_LVL = 2;
    localparam int ALC_LVL_OFFICE = 0;
    localparam int ALC_LVL_DARK = 1;

    ////////////////////////////////////////////////////////////////////////
    // backlight level chosen from the results
    typedef enum logic [1:0] {
        ALC_BL_DAYLIGHT,
        ALC_BL_OFFICE,
        ALC_BL_DARK
    } alc_level_t;

endpackage

/* src/alc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - sensor a filter code bits 7:5 select 80 ms times two to the code.
// - sensor b filter code bits 7:5 use the same 80 ms doubling encoding.
// - setting bit 4 of config a forces a sensor a conversion, backlight off and independent sinks on.
// - hardware clears the forced-read bit once results are valid.
// - forced read does nothing while the backlight runs; normal evaluation continues.
// - bit 4 of config b is the same forced read for sensor b.
// - config a bits 3 and 2 show sensor a dark and office results.
// - config b bits 3 and 2 show sensor b dark and office results.
// - config a bit 1 enables the sensor a dark comparator.
// - config a bit 0 enables the sensor a office comparator.
// - config b bit 1 enables the sensor b dark comparator.
// - config b bit 0 enables the sensor b office comparator.
// - dark result wins over office result when choosing the backlight level.
// - reading below the office trip level trips the office comparator.
// - reading above trip plus hysteresis releases it back to daylight.
module alc_ctrl
    import alc_pkg::*;
#(
    parameter int unsigned FILTER_BASE_CYC = ALC_SENSOR_A_FILTER_PERIOD_BASE_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic backlight_on,
    input wire logic indep_sinks_on,
    input wire logic [7:0] light_sense_input_a,
    input wire logic sample_valid_a,
    input wire logic [7:0] light_sense_input_b,
    input wire logic sample_valid_b,
    input wire logic [7:0] office_trip_level,
    input wire logic [7:0] office_hysteresis,
    input wire logic [7:0] dark_trip_level,
    input wire logic [7:0] dark_hysteresis,
    output logic conv_request_a,
    output logic conv_request_b,
    output logic [1:0] sensor_a_level,
    output logic [1:0] sensor_b_level
);

    ////////////////////////////////////////////////////////////////////////
    // per channel views of the ports

    logic [7:0] code [ALC_NUM_CH];
    logic smp [ALC_NUM_CH];
    logic [7:0] trip [ALC_NUM_LVL];
    logic [7:0] hys [ALC_NUM_LVL];
    logic [7:0] cfg_addr [ALC_NUM_CH];

    assign code[0] = light_sense_input_a;
    assign code[1] = light_sense_input_b;
    assign smp[0] = sample_valid_a;
    assign smp[1] = sample_valid_b;
    assign trip[ALC_LVL_OFFICE] = office_trip_level;
    assign trip[ALC_LVL_DARK] = dark_trip_level;
    assign hys[ALC_LVL_OFFICE] = office_hysteresis;
    assign hys[ALC_LVL_DARK] = dark_hysteresis;
    assign cfg_addr[0] = ALC_ADDR_CFG_A;
    assign cfg_addr[1] = ALC_ADDR_CFG_B;

    ////////////////////////////////////////////////////////////////////////
    // configuration, forced read and level state per channel

    logic [2:0] sensor_a_filter_period_ff [ALC_NUM_CH];
    logic [2:0] nxt_sensor_a_filter_period [ALC_NUM_CH];
    logic force_ff [ALC_NUM_CH];
    logic nxt_force [ALC_NUM_CH];
    logic [ALC_NUM_LVL-1:0] en_ff [ALC_NUM_CH];
    logic [ALC_NUM_LVL-1:0] nxt_en [ALC_NUM_CH];
    logic [ALC_NUM_LVL-1:0] res_ff [ALC_NUM_CH];
    logic [ALC_NUM_LVL-1:0] nxt_res [ALC_NUM_CH];
    logic [1:0] level_ff [ALC_NUM_CH];
    logic [1:0] nxt_level [ALC_NUM_CH];
    logic conv_ff [ALC_NUM_CH];
    logic nxt_conv [ALC_NUM_CH];
    logic force_go [ALC_NUM_CH];
    logic force_done [ALC_NUM_CH];
    logic [ALC_CNT_W-1:0] limit [ALC_NUM_CH];

    genvar c;
    genvar l;
    generate
        for (c = 0; c < ALC_NUM_CH; c = c + 1) begin : g_ch
            logic wr_hit;

            assign wr_hit = reg_wr && (reg_addr == cfg_addr[c]);
            // a pending request only runs with the backlight dark and sinks live
            assign force_go[c] = force_ff[c] && indep_sinks_on && !backlight_on;
            assign force_done[c] = force_go[c] && smp[c];
            // base interval doubled per code step; 10240 ms still fits 32 bits
            assign limit[c] = ALC_CNT_W'(FILTER_BASE_CYC) << sensor_a_filter_period_ff[c];

            always_comb begin
                nxt_sensor_a_filter_period[c] = sensor_a_filter_period_ff[c];
                nxt_en[c] = en_ff[c];
                nxt_force[c] = force_ff[c];
                if (force_done[c] || backlight_on) begin
                    nxt_force[c] = 1'b0;
                end
                if (wr_hit) begin
                    nxt_sensor_a_filter_period[c] = reg_wdata[ALC_SENSOR_A_FILTER_PERIOD_MSB:ALC_SENSOR_A_FILTER_PERIOD_LSB];
                    nxt_en[c][ALC_LVL_DARK] = reg_wdata[ALC_DARK_EN_BIT];
                    nxt_en[c][ALC_LVL_OFFICE] = reg_wdata[ALC_OFFICE_EN_BIT];
                    // a fresh request written as the old one finishes survives
                    if (reg_wdata[ALC_FORCE_BIT] && !backlight_on) begin
                        nxt_force[c] = 1'b1;
                    end
                end
                nxt_conv[c] = backlight_on || force_go[c];
                // dark wins over office
                if (nxt_res[c][ALC_LVL_DARK]) begin
                    nxt_level[c] = ALC_BL_DARK;
                end else if (nxt_res[c][ALC_LVL_OFFICE]) begin
                    nxt_level[c] = ALC_BL_OFFICE;
                end else begin
                    nxt_level[c] = ALC_BL_DAYLIGHT;
                end
            end

            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    sensor_a_filter_period_ff[c] <= ALC_CFG_RST[ALC_SENSOR_A_FILTER_PERIOD_MSB:ALC_SENSOR_A_FILTER_PERIOD_LSB];
                    force_ff[c] <= 1'b0;
                    en_ff[c] <= '0;
                    level_ff[c] <= ALC_BL_DAYLIGHT;
                    conv_ff[c] <= 1'b0;
                end else begin
                    sensor_a_filter_period_ff[c] <= nxt_sensor_a_filter_period[c];
                    force_ff[c] <= nxt_force[c];
                    en_ff[c] <= nxt_en[c];
                    level_ff[c] <= nxt_level[c];
                    conv_ff[c] <= nxt_conv[c];
                end
            end

            ////////////////////////////////////////////////////////////////
            // one filtered comparator per level

            for (l = 0; l < ALC_NUM_LVL; l = l + 1) begin : g_lvl
                logic [ALC_CNT_W-1:0] cnt_ff;
                logic [ALC_CNT_W-1:0] nxt_cnt;
                logic away_ff;
                logic nxt_away;
                logic want;
                logic [8:0] rel_level;

                assign rel_level = {1'b0, trip[l]} + {1'b0, hys[l]};

                always_comb begin
                    // hysteresis: trip below the level, release above level plus band
                    if (res_ff[c][l]) begin
                        want = !({1'b0, code[c]} > rel_level);
                    end else begin
                        want = code[c] < trip[l];
                    end
                    nxt_res[c][l] = res_ff[c][l];
                    nxt_cnt = cnt_ff;
                    nxt_away = away_ff;
                    if (!en_ff[c][l]) begin
                        nxt_res[c][l] = 1'b0;
                        nxt_cnt = '0;
                        nxt_away = 1'b0;
                    end else if (force_done[c]) begin
                        // a forced read has no history to filter against
                        nxt_res[c][l] = want;
                        nxt_cnt = '0;
                        nxt_away = 1'b0;
                    end else if (!backlight_on) begin
                        // no readings come with the backlight dark, so a half-run interval starts over
                        nxt_cnt = '0;
                        nxt_away = 1'b0;
                    end else begin
                        if (smp[c]) begin
                            nxt_away = want != res_ff[c][l];
                        end
                        if (!nxt_away) begin
                            nxt_cnt = '0;
                        end else if (cnt_ff >= limit[c] - 1'b1) begin
                            nxt_res[c][l] = !res_ff[c][l];
                            nxt_cnt = '0;
                            nxt_away = 1'b0;
                        end else begin
                            nxt_cnt = cnt_ff + 1'b1;
                        end
                    end
                end

                always_ff @(posedge clock or negedge rstn) begin
                    if (!rstn) begin
                        cnt_ff <= '0;
                        away_ff <= 1'b0;
                        res_ff[c][l] <= 1'b0;
                    end else begin
                        cnt_ff <= nxt_cnt;
                        away_ff <= nxt_away;
                        res_ff[c][l] <= nxt_res[c][l];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read back, one cycle behind the address

    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    function automatic logic [7:0] pack_cfg(
        input logic [2:0] f,
        input logic fr,
        input logic [1:0] r,
        input logic [1:0] e
    );
        logic [7:0] v;
        v = 8'h00;
        v[ALC_SENSOR_A_FILTER_PERIOD_MSB:ALC_SENSOR_A_FILTER_PERIOD_LSB] = f;
        v[ALC_FORCE_BIT] = fr;
        v[ALC_DARK_RES_BIT] = r[ALC_LVL_DARK];
        v[ALC_OFFICE_RES_BIT] = r[ALC_LVL_OFFICE];
        v[ALC_DARK_EN_BIT] = e[ALC_LVL_DARK];
        v[ALC_OFFICE_EN_BIT] = e[ALC_LVL_OFFICE];
        return v;
    endfunction

    always_comb begin
        case (reg_addr)
            ALC_ADDR_CFG_A: begin
                nxt_rdata = pack_cfg(sensor_a_filter_period_ff[0], force_ff[0], res_ff[0], en_ff[0]);
            end
            ALC_ADDR_CFG_B: begin
                nxt_rdata = pack_cfg(sensor_a_filter_period_ff[1], force_ff[1], res_ff[1], en_ff[1]);
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = rdata_ff;
    assign conv_request_a = conv_ff[0];
    assign conv_request_b = conv_ff[1];
    assign sensor_a_level = level_ff[0];
    assign sensor_b_level = level_ff[1];

endmodule // alc_ctrl

`default_nettype wire

/* dv/alc_ctrl_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module alc_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic backlight_on,
    input wire logic indep_sinks_on,
    input wire logic sample_valid_a,
    input wire logic conv_request_a,
    input wire logic conv_request_b,
    input wire logic [1:0] sensor_a_level,
    input wire logic [1:0] sensor_b_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // read-back and level are taken from the same result snapshot, so they must agree
    // level moves with the result flop, read data one cycle later, so compare against last cycle's level
    AST_LVL_A: assert property ($past(reg_addr) == 8'h1b |-> $past(sensor_a_level) == (reg_rdata[3] ? 2'h2 : {1'b0, reg_rdata[2]}))
        else $error("sensor a level disagrees with its result bits");
    AST_LVL_B: assert property ($past(reg_addr) == 8'h1c |-> $past(sensor_b_level) == (reg_rdata[3] ? 2'h2 : {1'b0, reg_rdata[2]}))
        else $error("sensor b level disagrees with its result bits");
    AST_CONV_BL: assert property (backlight_on |=> conv_request_a && conv_request_b)
        else $error("conversions not requested while backlight runs");
    AST_CONV_IDLE: assert property (!backlight_on && !indep_sinks_on |=> !conv_request_a && !conv_request_b)
        else $error("conversion requested with sinks and backlight off");
    AST_FORCE_DONE: assert property (!backlight_on && !$past(backlight_on) && indep_sinks_on && conv_request_a
        && sample_valid_a && !reg_wr ##1 (!backlight_on && indep_sinks_on) |=> !conv_request_a)
        else $error("forced read of sensor a not finished by its sample");
    AST_FORCE_DROP: assert property (reg_wr && reg_addr == 8'h1b && reg_wdata[4] && backlight_on ##1 reg_addr == 8'h1b |=> !reg_rdata[4])
        else $error("forced read accepted while backlight runs");
    AST_CFG: assert property (reg_wr && reg_addr inside {8'h1b, 8'h1c} ##1 reg_addr == $past(reg_addr) |=>
        reg_rdata[7:5] == $past(reg_wdata[7:5], 2) && reg_rdata[1:0] == $past(reg_wdata[1:0], 2))
        else $error("filter or enable field not read back as written");
    AST_OFF_A: assert property ($past(reg_addr) == 8'h1b && $past(reg_addr, 2) == 8'h1b && !reg_rdata[0] && !$past(reg_rdata[0]) |-> !reg_rdata[2])
        else $error("disabled office comparator of sensor a shows a result");
    AST_OFF_B: assert property ($past(reg_addr) == 8'h1c && $past(reg_addr, 2) == 8'h1c && !reg_rdata[1] && !$past(reg_rdata[1]) |-> !reg_rdata[3])
        else $error("disabled dark comparator of sensor b shows a result");
    COV_DARK: cover property (sensor_a_level == 2'h2);
    COV_FORCED: cover property ($fell(conv_request_a) && !backlight_on);
    COV_OFFICE_B: cover property (sensor_b_level == 2'h1);
endmodule // alc_chk
bind alc_ctrl alc_chk u_chk (.clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .backlight_on(backlight_on), .indep_sinks_on(indep_sinks_on), .sample_valid_a(sample_valid_a),
    .conv_request_a(conv_request_a), .conv_request_b(conv_request_b), .sensor_a_level(sensor_a_level),
    .sensor_b_level(sensor_b_level));
`default_nettype wire

/* dv/alc_sensor_model.sv */
`timescale 1ns/10ps
`default_nettype none
// one code every GAP cycles while asked; the line toggles in between so a stale code is never usable
module alc_sensor_model #(
    parameter int GAP = 3
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic conv_request,
    input wire logic [7:0] code,
    output logic [7:0] light_sense_input,
    output logic sample_valid
);
    int cnt_ff;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 0;
            sample_valid <= 1'b0;
            light_sense_input <= 8'h00;
        end else begin
            cnt_ff <= (conv_request && cnt_ff < GAP - 1) ? cnt_ff + 1 : 0;
            sample_valid <= conv_request && cnt_ff == GAP - 1;
            light_sense_input <= (conv_request && cnt_ff == GAP - 1) ? code : ~light_sense_input;
        end
    end
endmodule // alc_sensor_model
`default_nettype wire

/* dv/alc_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module alc_ctrl_tb;
    localparam int BASE = 4;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic backlight_on = 1'b0;
    logic indep_sinks_on = 1'b0;
    logic [7:0] code [2] = '{8'h80, 8'h80};
    logic [7:0] thr [4] = '{8'h40, 8'h10, 8'h20, 8'h10};
    logic look = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] sense [2];
    logic valid [2];
    logic conv [2];
    logic [1:0] lvl_a, lvl_b;
    logic [11:0] exp_q [$], msk_q [$];
    logic [11:0] e, m;
    int fails = 0, n_checks = 0, cycles = 0, f, lim;
    int seed = 32'h10097143;
    initial forever #12.5 clock = ~clock;
    // thresholds held fixed: office trips below 40, releases above 50; dark below 20, above 30
    alc_ctrl #(.FILTER_BASE_CYC(BASE)) dut (.clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .backlight_on(backlight_on), .indep_sinks_on(indep_sinks_on),
        .light_sense_input_a(sense[0]), .sample_valid_a(valid[0]), .light_sense_input_b(sense[1]),
        .sample_valid_b(valid[1]), .office_trip_level(thr[0]), .office_hysteresis(thr[1]), .dark_trip_level(thr[2]),
        .dark_hysteresis(thr[3]), .conv_request_a(conv[0]), .conv_request_b(conv[1]), .sensor_a_level(lvl_a),
        .sensor_b_level(lvl_b));
    alc_sensor_model #(.GAP(2)) u_sen_a (.clock(clock), .rstn(rstn), .conv_request(conv[0]), .code(code[0]),
        .light_sense_input(sense[0]), .sample_valid(valid[0]));
    alc_sensor_model #(.GAP(5)) u_sen_b (.clock(clock), .rstn(rstn), .conv_request(conv[1]), .code(code[1]),
        .light_sense_input(sense[1]), .sample_valid(valid[1]));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [11:0] ex, input logic [11:0] mk);
        @(posedge clock);
        reg_addr <= a;
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        @(posedge clock);
        look <= 1'b1;
        @(posedge clock);
        look <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // word seen is {level b, level a, read data}
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
        if (look) begin
            n_checks++;
            if ((({lvl_b, lvl_a, reg_rdata} ^ exp_q[0]) & msk_q[0]) !== 12'h000) begin
                fails++;
                $display("unexpected read word: expected %h seen %h", exp_q[0] & msk_q[0], {lvl_b, lvl_a, reg_rdata});
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        rd(8'h1b, 12'h000, 12'hfff);
        rd(8'h1c, 12'h000, 12'hfff);
        rd(8'h1d, 12'h000, 12'h0ff);
        $display("test reset done");
        // with sinks off a forced read stays pending until backlight takes over
        for (int s = 0; s < 2; s++) begin
            wr(8'(27 + s), 8'hff);
            rd(8'(27 + s), 12'h0f3, 12'h0ff);
        end
        backlight_on <= 1'b1;
        for (int s = 0; s < 2; s++) rd(8'(27 + s), 12'h0e3, 12'h0ff);
        $display("test write masks done");
        backlight_on <= 1'b0;
        indep_sinks_on <= 1'b1;
        code[0] <= 8'h10;
        code[1] <= 8'h10;
        wr(8'h1b, 8'h13);
        wr(8'h1c, 8'h11);
        repeat (2) @(posedge clock);
        while (conv[0] || conv[1]) @(posedge clock);
        rd(8'h1b, 12'h60f, 12'hfff);
        rd(8'h1c, 12'h605, 12'hfff);
        $display("test forced read done");
        backlight_on <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            f = int'($unsigned($random(seed)) % 8);
            lim = BASE << f;
            e = 12'((1 << (8 + 2 * s)) | (f << 5) | 5);
            m = 12'((3 << (8 + 2 * s)) | 255);
            wr(8'(27 + s), {f[2:0], 5'b10001});
            rd(8'(27 + s), e, m);
            code[s] <= 8'h41 + 8'($unsigned($random(seed)) % 16);
            repeat (lim + lim / 2) @(posedge clock);
            rd(8'(27 + s), e, m);
            code[s] <= 8'h60;
            repeat (lim * 3 / 4 - 3) @(posedge clock);
            rd(8'(27 + s), e, m);
            repeat (lim / 2 + 10) @(posedge clock);
            rd(8'(27 + s), 12'((f << 5) | 1), m);
            $display("test filter channel %0d done", s);
        end
        close_out();
    end
endmodule // alc_ctrl_tb
`default_nettype wire
